// >>> rtl/avc_defs.vh
`ifndef AVC_DEFS_VH
`define AVC_DEFS_VH
// ---------------------------------------------
// timing
// ---------------------------------------------
`define AVC_CLK_HZ 25000000
`define AVC_TICK_MS 10
`define AVC_TICK_CYC (`AVC_CLK_HZ / 1000 * `AVC_TICK_MS)
`define AVC_DEB_MS 20
`define AVC_DEB_TICKS (`AVC_DEB_MS / `AVC_TICK_MS)
`define AVC_HOLD_S 3
`define AVC_HOLD_TICKS (`AVC_HOLD_S * 1000 / `AVC_TICK_MS)
`define AVC_DELAY_S 5
`define AVC_DELAY_TICKS (`AVC_DELAY_S * 1000 / `AVC_TICK_MS)
`define AVC_WIN_MIN 5
`define AVC_WIN_TICKS (`AVC_WIN_MIN * 60000 / `AVC_TICK_MS)
`define AVC_MSG_S 2
`define AVC_MSG_TICKS (`AVC_MSG_S * 1000 / `AVC_TICK_MS)
// ---------------------------------------------
// switch bank positions (bit n is position n+1, 1 = on)
// ---------------------------------------------
`define AVC_SW_RANGE_A 0
`define AVC_SW_RANGE_B 1
`define AVC_SW_UNIT_A 3
`define AVC_SW_UNIT_B 4
`define AVC_SW_VSPAN 5
`define AVC_SW_DIRECT 6
// ---------------------------------------------
// full scale values
// ---------------------------------------------
`define AVC_FS_IMP_4 16'h0FA0
`define AVC_FS_IMP_3 16'h0BB8
`define AVC_FS_IMP_2 16'h07D0
`define AVC_FS_IMP_1 16'h03E8
`define AVC_FS_MET_4 16'h0014
`define AVC_FS_MET_3 16'h000F
`define AVC_FS_MET_2 16'h000A
`define AVC_FS_MET_1 16'h0005
// ---------------------------------------------
// display message codes
// ---------------------------------------------
`define AVC_MSG_HOME 4'h0
`define AVC_MSG_ZERO 4'h1
`define AVC_MSG_SPAN 4'h2
`define AVC_MSG_FAULT 4'h3
`define AVC_MSG_OVER 4'h4
`define AVC_MSG_UNDER 4'h5
`define AVC_MSG_DAMAGE 4'h6
`define AVC_MSG_SECU 4'h7
`define AVC_MSG_LEVEL 4'h8
`define AVC_MSG_CODE 4'h9
`define AVC_MSG_MENU 4'hA
// ---------------------------------------------
// register map and reset values
// ---------------------------------------------
`define AVC_REG_STATUS 8'h00
`define AVC_REG_CAL_LO 8'h04
`define AVC_REG_CAL_HI 8'h08
`define AVC_REG_ZERO 8'h0C
`define AVC_REG_SPAN 8'h10
`define AVC_CAL_LO_RST 16'h0000
`define AVC_CAL_HI_RST 16'hFFFF
`define AVC_LVL_RST 2'h0
`define AVC_DIGIT_MAX 4'h9
`define AVC_LVL_MAX 4'h3
`endif

// >>> rtl/avc_tick.v
`timescale 1ns/1ps
`include "avc_defs.vh"
// ---------------------------------------------
// fixed timing tick
// ---------------------------------------------
module avc_tick #(
  parameter TICK_CYC = `AVC_TICK_CYC
) (
  input wire clk_i,
  input wire rst_i,
  output reg tick_o
);
  localparam [31:0] LAST = TICK_CYC - 1;
  reg [23:0] cnt;

  // one-cycle tick every TICK_CYC clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 24'h000000;
      tick_o <= 1'b0;
    end else if (cnt == LAST[23:0]) begin
      cnt <= 24'h000000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 24'h000001;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> rtl/avc_btn.v
`timescale 1ns/1ps
`include "avc_defs.vh"
// ---------------------------------------------
// button debounce and hold timer
// ---------------------------------------------
module avc_btn #(
  parameter [15:0] DEB = `AVC_DEB_TICKS,
  parameter [15:0] HOLD = `AVC_HOLD_TICKS
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire raw_i,
  output reg level_o,
  output reg tap_o,
  output reg hold_o
);
  reg [15:0] deb_cnt;
  reg [15:0] hold_cnt;
  reg held;

  // raw level must differ from the accepted one for DEB ticks
  always @(posedge clk_i) begin
    if (rst_i) begin
      deb_cnt <= 16'h0000;
      level_o <= 1'b0;
    end else if (tick_i) begin
      if (raw_i == level_o) begin
        deb_cnt <= 16'h0000;
      end else if (deb_cnt + 16'h0001 >= DEB) begin
        deb_cnt <= 16'h0000;
        level_o <= raw_i;
      end else begin
        deb_cnt <= deb_cnt + 16'h0001;
      end
    end
  end

  // hold pulse once per press; tap only for a release accepted before or on the tick of the hold
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= 16'h0000;
      held <= 1'b0;
      hold_o <= 1'b0;
      tap_o <= 1'b0;
    end else begin
      hold_o <= 1'b0;
      tap_o <= 1'b0;
      if (!level_o) begin
        hold_cnt <= 16'h0000;
        held <= 1'b0;
      end else if (tick_i && !held) begin
        if (hold_cnt + 16'h0001 >= HOLD) begin
          held <= 1'b1;
          hold_o <= 1'b1;
        end
        hold_cnt <= hold_cnt + 16'h0001;
      end
      if (tick_i && level_o && !raw_i && deb_cnt + 16'h0001 >= DEB && !held) begin
        tap_o <= 1'b1;
      end
    end
  end
endmodule

// >>> rtl/avc_top.v
`timescale 1ns/1ps
`include "avc_defs.vh"
// Operation
// - switch positions 1 and 2 pick full scale 4000/3000/2000/1000 FEET_PER_MINUTE_UNIT or 20/15/10/5 m/s.
// - imperial units only when positions 4 and 5 are both on, else metric.
// - position 6 on gives 0-10 VDC span, off gives 0-5 VDC.
// - position 7 on gives direct output, off gives inverted output.
// - the second and third switch banks are reserved and ignored.
// - calibration change is applied 5 seconds after the button is released.
// - zero held 3 seconds captures reading as zero, shows zero message, returns home.
// - span accepted only after zero and within 5 minutes of it; a span later than that is ignored.
// - span held 3 seconds stores present reading as span reference, shows span message.
// - span tried before any zero shows the calibration fault message briefly.
// - velocity above maximum span flags over-range.
// - velocity below minimum span flags under-range.
// - reading outside the valid setting window at a press shows calibration fault.
// - a failed sensor shows a distinct damage indication.
// - home state shows the measured value and its unit.
// - both buttons held at home show security prompt, release shows level.
// - span held 3 seconds at the level screen enters the mode menu.
// - zero at level screen opens 3-digit code editor; span selects, zero increments.
// - a lower-level code is temporary, a higher-level code is persistent.
// - 000 allows all, 111 view and zero only, 222 and 333 nothing.
// - start in velocity mode; flow mode only via menu with display attached.
module avc_top #(
  parameter TICK_CYC = `AVC_TICK_CYC,
  parameter [15:0] DEB = `AVC_DEB_TICKS,
  parameter [15:0] HOLD = `AVC_HOLD_TICKS,
  parameter [15:0] DELAY = `AVC_DELAY_TICKS,
  parameter [15:0] WIN = `AVC_WIN_TICKS,
  parameter [15:0] MSGT = `AVC_MSG_TICKS
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] analog_config_switch_bank_i,
  input wire zero_btn_i,
  input wire span_btn_i,
  input wire display_present_i,
  input wire sensor_fault_i,
  input wire [15:0] velocity_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [15:0] full_scale_o,
  output reg unit_imperial_o,
  output reg vout_10v_o,
  output reg out_direct_o,
  output reg [15:0] out_level_o,
  output reg [3:0] msg_o,
  output reg [1:0] sec_level_o,
  output reg [11:0] code_o,
  output reg [1:0] code_pos_o,
  output reg flow_mode_o,
  output reg over_range_o,
  output reg under_range_o
);
  // ---------------------------------------------
  // states
  // ---------------------------------------------
  localparam [2:0] S_HOME = 3'h0;
  localparam [2:0] S_SECP = 3'h1;
  localparam [2:0] S_SECL = 3'h2;
  localparam [2:0] S_CODE = 3'h3;
  localparam [2:0] S_MENU = 3'h4;
  localparam [2:0] S_MSG = 3'h5;
  localparam [2:0] S_CALW = 3'h6;
  localparam [1:0] A_VIEW = 2'h0;
  localparam [1:0] A_ZERO = 2'h1;
  localparam [1:0] A_SPAN = 2'h2;

  reg [2:0] state;
  reg [15:0] cnt;
  reg [15:0] win_cnt;
  reg zero_done;
  reg cal_span;
  reg released;
  reg [1:0] pers_lvl;
  reg [1:0] temp_lvl;
  reg temp_v;
  reg [3:0] dig0;
  reg [3:0] dig1;
  reg [3:0] dig2;
  reg [15:0] zero_ref;
  reg [15:0] span_ref;
  reg [15:0] cal_lo;
  reg [15:0] cal_hi;
  reg [15:0] next_fs;
  reg [15:0] next_corr;
  wire tick;
  wire z_lvl;
  wire z_tap;
  wire z_hold;
  wire s_lvl;
  wire s_tap;
  wire s_hold;
  wire [1:0] lvl;
  wire in_win;
  wire win_ok;
  wire code_ok;
  wire wb_req;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // access table by security level
  function acc;
    input [1:0] level;
    input [1:0] what;
    begin
      case (what)
        A_VIEW: acc = (level == 2'h0) || (level == 2'h1);
        A_ZERO: acc = (level == 2'h0) || (level == 2'h1);
        A_SPAN: acc = (level == 2'h0);
        default: acc = 1'b0;
      endcase
    end
  endfunction

  // code digit step wraps after nine
  function [3:0] dig_inc;
    input [3:0] d;
    begin
      dig_inc = (d == `AVC_DIGIT_MAX) ? 4'h0 : d + 4'h1;
    end
  endfunction

  // ---------------------------------------------
  // tick and buttons
  // ---------------------------------------------
  avc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  avc_btn #(.DEB(DEB), .HOLD(HOLD)) u_zero (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .raw_i(zero_btn_i),
    .level_o(z_lvl),
    .tap_o(z_tap),
    .hold_o(z_hold)
  );

  avc_btn #(.DEB(DEB), .HOLD(HOLD)) u_span (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .raw_i(span_btn_i),
    .level_o(s_lvl),
    .tap_o(s_tap),
    .hold_o(s_hold)
  );

  // ---------------------------------------------
  // configuration decode
  // ---------------------------------------------
  // reserved switch banks have no input at all, so they cannot steer anything
  always @* begin
    case ({analog_config_switch_bank_i[`AVC_SW_RANGE_A], analog_config_switch_bank_i[`AVC_SW_RANGE_B]})
      2'h3: next_fs = unit_imperial_o ? `AVC_FS_IMP_4 : `AVC_FS_MET_4;
      2'h2: next_fs = unit_imperial_o ? `AVC_FS_IMP_3 : `AVC_FS_MET_3;
      2'h1: next_fs = unit_imperial_o ? `AVC_FS_IMP_2 : `AVC_FS_MET_2;
      default: next_fs = unit_imperial_o ? `AVC_FS_IMP_1 : `AVC_FS_MET_1;
    endcase
    // corrected reading, clamped to full scale
    if (velocity_i <= zero_ref) begin
      next_corr = 16'h0000;
    end else if (velocity_i - zero_ref > full_scale_o) begin
      next_corr = full_scale_o;
    end else begin
      next_corr = velocity_i - zero_ref;
    end
  end

  // switches are only read at power-up in the field, but sampling them live is harmless
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_imperial_o <= 1'b0;
      full_scale_o <= `AVC_FS_MET_1;
      vout_10v_o <= 1'b0;
      out_direct_o <= 1'b0;
      out_level_o <= 16'h0000;
      over_range_o <= 1'b0;
      under_range_o <= 1'b0;
    end else begin
      unit_imperial_o <= analog_config_switch_bank_i[`AVC_SW_UNIT_A] &
                         analog_config_switch_bank_i[`AVC_SW_UNIT_B];
      full_scale_o <= next_fs;
      vout_10v_o <= analog_config_switch_bank_i[`AVC_SW_VSPAN];
      out_direct_o <= analog_config_switch_bank_i[`AVC_SW_DIRECT];
      out_level_o <= out_direct_o ? next_corr : full_scale_o - next_corr;
      over_range_o <= velocity_i > cal_hi;
      under_range_o <= velocity_i < cal_lo;
    end
  end

  // ---------------------------------------------
  // calibration window and security level
  // ---------------------------------------------
  assign in_win = (velocity_i >= cal_lo) && (velocity_i <= cal_hi);
  assign win_ok = zero_done && (win_cnt < WIN);
  assign lvl = temp_v ? temp_lvl : pers_lvl;
  assign code_ok = (dig0 == dig1) && (dig1 == dig2) && (dig0 <= `AVC_LVL_MAX);

  // ticks since the last zero; saturates so the window stays closed
  always @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt <= 16'h0000;
    end else if (state == S_CALW && !cal_span && released && tick && cnt + 16'h0001 >= DELAY) begin
      win_cnt <= 16'h0000;
    end else if (tick && win_cnt < WIN) begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------
  // main state machine
  // ---------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_HOME;
      cnt <= 16'h0000;
      zero_done <= 1'b0;
      cal_span <= 1'b0;
      released <= 1'b0;
      pers_lvl <= `AVC_LVL_RST;
      temp_lvl <= `AVC_LVL_RST;
      temp_v <= 1'b0;
      dig0 <= 4'h0;
      dig1 <= 4'h0;
      dig2 <= 4'h0;
      code_pos_o <= 2'h0;
      zero_ref <= 16'h0000;
      span_ref <= 16'h0000;
      flow_mode_o <= 1'b0;
      msg_o <= `AVC_MSG_HOME;
    end else begin
      case (state)
        S_HOME: begin
          if (sensor_fault_i) begin
            msg_o <= `AVC_MSG_DAMAGE;
          end else if (over_range_o) begin
            msg_o <= `AVC_MSG_OVER;
          end else if (under_range_o) begin
            msg_o <= `AVC_MSG_UNDER;
          end else begin
            msg_o <= `AVC_MSG_HOME;
          end
          if (z_lvl && s_lvl) begin
            state <= S_SECP;
            msg_o <= `AVC_MSG_SECU;
          end else if (z_hold && acc(lvl, A_ZERO)) begin
            cnt <= 16'h0000;
            if (!in_win) begin
              state <= S_MSG;
              msg_o <= `AVC_MSG_FAULT;
            end else begin
              state <= S_CALW;
              cal_span <= 1'b0;
              released <= 1'b0;
            end
          end else if (s_hold && acc(lvl, A_SPAN)) begin
            cnt <= 16'h0000;
            if (!zero_done || !in_win) begin
              state <= S_MSG;
              msg_o <= `AVC_MSG_FAULT;
            end else if (win_ok) begin
              state <= S_CALW;
              cal_span <= 1'b1;
              released <= 1'b0;
            end
          end
        end
        S_SECP: begin
          // wait for both buttons to come up before showing the level
          if (!z_lvl && !s_lvl) begin
            state <= S_SECL;
            msg_o <= `AVC_MSG_LEVEL;
          end
        end
        S_SECL: begin
          if (s_hold) begin
            if (acc(lvl, A_VIEW)) begin
              state <= S_MENU;
              msg_o <= `AVC_MSG_MENU;
            end else begin
              state <= S_HOME;
              temp_v <= 1'b0;
            end
          end else if (z_tap) begin
            state <= S_CODE;
            msg_o <= `AVC_MSG_CODE;
            dig0 <= 4'h0;
            dig1 <= 4'h0;
            dig2 <= 4'h0;
            code_pos_o <= 2'h0;
          end
        end
        S_CODE: begin
          if (s_hold) begin
            cnt <= 16'h0000;
            if (!code_ok) begin
              state <= S_MSG;
              msg_o <= `AVC_MSG_FAULT;
            end else if (dig0[1:0] < lvl) begin
              temp_lvl <= dig0[1:0];
              temp_v <= 1'b1;
              state <= S_SECL;
              msg_o <= `AVC_MSG_LEVEL;
            end else begin
              pers_lvl <= dig0[1:0];
              temp_v <= 1'b0;
              state <= S_SECL;
              msg_o <= `AVC_MSG_LEVEL;
            end
          end else if (s_tap) begin
            code_pos_o <= (code_pos_o == 2'h2) ? 2'h0 : code_pos_o + 2'h1;
          end else if (z_tap) begin
            case (code_pos_o)
              2'h0: dig0 <= dig_inc(dig0);
              2'h1: dig1 <= dig_inc(dig1);
              default: dig2 <= dig_inc(dig2);
            endcase
          end
        end
        S_MENU: begin
          if (s_hold) begin
            state <= S_HOME;
            temp_v <= 1'b0;
          end else if (z_tap && display_present_i && acc(lvl, A_VIEW)) begin
            flow_mode_o <= ~flow_mode_o;
          end
        end
        S_MSG: begin
          // confirmation and fault messages stand for a fixed time
          if (tick) begin
            if (cnt + 16'h0001 >= MSGT) begin
              state <= S_HOME;
              msg_o <= `AVC_MSG_HOME;
            end
            cnt <= cnt + 16'h0001;
          end
        end
        S_CALW: begin
          // delay starts at release so hand movement does not upset the reading
          if (!released) begin
            if (!z_lvl && !s_lvl) begin
              released <= 1'b1;
              cnt <= 16'h0000;
            end
          end else if (tick) begin
            cnt <= cnt + 16'h0001;
            if (cnt + 16'h0001 >= DELAY) begin
              cnt <= 16'h0000;
              state <= S_MSG;
              if (cal_span) begin
                span_ref <= velocity_i;
                msg_o <= `AVC_MSG_SPAN;
              end else begin
                zero_ref <= velocity_i;
                zero_done <= 1'b1;
                msg_o <= `AVC_MSG_ZERO;
              end
            end
          end
        end
        default: begin
          state <= S_HOME;
        end
      endcase
    end
  end

  // level and code shown on the display
  always @(posedge clk_i) begin
    if (rst_i) begin
      sec_level_o <= `AVC_LVL_RST;
      code_o <= 12'h000;
    end else begin
      sec_level_o <= lvl;
      code_o <= {dig2, dig1, dig0};
    end
  end

  // ---------------------------------------------
  // wishbone slave
  // ---------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ack one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cal_lo <= `AVC_CAL_LO_RST;
      cal_hi <= `AVC_CAL_HI_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
        if (wb_adr_i == `AVC_REG_CAL_LO) begin
          if (wb_sel_i[0]) cal_lo[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cal_lo[15:8] <= wb_dat_i[15:8];
        end
        if (wb_adr_i == `AVC_REG_CAL_HI) begin
          if (wb_sel_i[0]) cal_hi[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cal_hi[15:8] <= wb_dat_i[15:8];
        end
      end
      case (wb_adr_i)
        `AVC_REG_STATUS: wb_dat_o <= {21'h000000, temp_v, under_range_o, over_range_o,
                                      flow_mode_o, lvl, win_ok, zero_done, state};
        `AVC_REG_CAL_LO: wb_dat_o <= {16'h0000, cal_lo};
        `AVC_REG_CAL_HI: wb_dat_o <= {16'h0000, cal_hi};
        `AVC_REG_ZERO: wb_dat_o <= {16'h0000, zero_ref};
        `AVC_REG_SPAN: wb_dat_o <= {16'h0000, span_ref};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// >>> sim/avc_exp.svh
// full scale from the two range positions, in the unit set by positions 4 and 5
function automatic [15:0] fs_of(input [7:0] s);
  reg imp;
  begin
    imp = s[3] & s[4];
    case ({s[0], s[1]})
      2'h3: fs_of = imp ? `AVC_FS_IMP_4 : `AVC_FS_MET_4;
      2'h2: fs_of = imp ? `AVC_FS_IMP_3 : `AVC_FS_MET_3;
      2'h1: fs_of = imp ? `AVC_FS_IMP_2 : `AVC_FS_MET_2;
      default: fs_of = imp ? `AVC_FS_IMP_1 : `AVC_FS_MET_1;
    endcase
  end
endfunction

// >>> sim/avc_panel.sv
`timescale 1ns/1ps
// ----
// push-button panel
// ----
module avc_panel #(
  parameter [15:0] TCYC = 16'h000A
) (
  input wire clk_i,
  input wire [1:0] press_i,
  input wire [7:0] ticks_i,
  input wire go_i,
  output reg zero_btn_o = 1'h0,
  output reg span_btn_o = 1'h0,
  output reg busy_o = 1'h0
);
  reg [1:0] pick;
  reg [1:0] age;
  reg [15:0] cnt;
  // contacts chatter on the first cycles of a press; both buttons move as one gesture
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'h1;
      pick <= press_i;
      age <= 2'h0;
      cnt <= {8'h00, ticks_i} * TCYC;
    end else if (busy_o) begin
      cnt <= cnt - 16'h0001;
      age <= (age == 2'h3) ? age : age + 2'h1;
      {span_btn_o, zero_btn_o} <= age[0] ? pick : 2'h0;
      if (cnt == 16'h0000) begin
        busy_o <= 1'h0;
        {span_btn_o, zero_btn_o} <= 2'h0;
      end
    end
  end
endmodule

// >>> sim/avc_monitor.sv
`timescale 1ns/1ps
`include "avc_defs.vh"
module avc_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] analog_config_switch_bank_i,
  input wire sensor_fault_i,
  input wire [15:0] velocity_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire [15:0] full_scale_o,
  input wire unit_imperial_o,
  input wire vout_10v_o,
  input wire out_direct_o,
  input wire [3:0] msg_o,
  input wire over_range_o,
  input wire under_range_o
);
  `include "avc_exp.svh"
  wire [7:0] sw = analog_config_switch_bank_i;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  reg [2:0] up;
  reg [15:0] lo;
  reg [15:0] hi;
  // ----
  // helpers
  // ----
  // shadow of the window registers; only full-word writes are tracked
  always @(posedge clk_i) begin
    if (rst_i) begin
      up <= 3'h0;
      lo <= `AVC_CAL_LO_RST;
      hi <= `AVC_CAL_HI_RST;
    end else begin
      up <= up + {2'h0, up != 3'h7};
      if (wr && wb_adr_i == `AVC_REG_CAL_LO)
        lo <= wb_dat_i[15:0];
      if (wr && wb_adr_i == `AVC_REG_CAL_HI)
        hi <= wb_dat_i[15:0];
    end
  end
  // ----
  // properties
  // ----
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // inputs held long enough for the registered outputs to follow
  sequence calm;
    (up == 3'h7 && $stable(sw) && $stable(velocity_i) && $stable(lo) && $stable(hi)) [*3];
  endsequence
  AST_RANGE: assert property (calm |-> full_scale_o == fs_of(sw))
    else $error("full scale wrong");
  AST_UNITS: assert property (calm |-> unit_imperial_o == (sw[3] & sw[4]))
    else $error("unit select wrong");
  AST_VSPAN: assert property (calm |-> vout_10v_o == sw[5])
    else $error("voltage span wrong");
  AST_ACTION: assert property (calm |-> out_direct_o == sw[6])
    else $error("output action wrong");
  AST_OVER: assert property (calm |-> over_range_o == (velocity_i > hi))
    else $error("over range flag wrong");
  AST_UNDER: assert property (calm |-> under_range_o == (velocity_i < lo))
    else $error("under range flag wrong");
  AST_DAMAGE: assert property (msg_o == `AVC_MSG_DAMAGE |->
    sensor_fault_i || $past(sensor_fault_i) || $past(sensor_fault_i, 2))
    else $error("damage shown without fault");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
endmodule
bind avc_top avc_monitor i_mon (.clk_i, .rst_i, .analog_config_switch_bank_i, .sensor_fault_i, .velocity_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .full_scale_o, .unit_imperial_o,
  .vout_10v_o, .out_direct_o, .msg_o, .over_range_o, .under_range_o);

// >>> sim/avc_top_tb.sv
`timescale 1ns/1ps
`include "avc_defs.vh"
module avc_top_tb;
  `include "avc_exp.svh"
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg [7:0] sw = 8'hFF;
  reg [7:0] s;
  reg fault = 1'h0;
  reg [15:0] vel = 16'h0096;
  reg [15:0] x;
  reg cyc = 1'h0;
  reg we = 1'h0;
  reg [3:0] sel = 4'h0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0;
  reg [31:0] q;
  reg [31:0] seed = 32'h00015837;
  reg [1:0] btn = 2'h0;
  reg [7:0] len = 8'h00;
  reg go = 1'h0;
  reg disp = 1'h1;
  integer n_errors = 0;
  integer check_count = 0;
  integer k;
  wire zb, sb, busy, ack, imp, v10, dir, ovr, und, flow;
  wire [31:0] rd;
  wire [15:0] fs, lvl;
  wire [1:0] sl;
  wire [3:0] msg;
  // ----
  // parts
  // ----
  avc_panel i_panel (.clk_i(clk_i), .press_i(btn), .ticks_i(len), .go_i(go), .zero_btn_o(zb), .span_btn_o(sb),
    .busy_o(busy));
  // short counts keep the run small; one tick is ten clocks
  avc_top #(.TICK_CYC(32'h0000000A), .HOLD(16'h0004), .DELAY(16'h0004), .WIN(16'h0014), .MSGT(16'h0003)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .analog_config_switch_bank_i(sw), .zero_btn_i(zb), .span_btn_i(sb),
    .display_present_i(disp), .sensor_fault_i(fault), .velocity_i(vel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .full_scale_o(fs), .unit_imperial_o(imp), .vout_10v_o(v10), .out_direct_o(dir), .out_level_o(lvl),
    .msg_o(msg), .sec_level_o(sl), .code_o(), .code_pos_o(), .flow_mode_o(flow), .over_range_o(ovr),
    .under_range_o(und));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ----
  // tasks
  // ----
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  task wrap_up;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // classic single cycle: everything holds until ack is sampled high
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      i = 0;
      @(posedge clk_i);
      while (ack !== 1'h1 && i < 32) begin
        @(posedge clk_i);
        i = i + 1;
      end
      q = rd;
      cyc <= 1'h0;
      we <= 1'h0;
      if (ack !== 1'h1) begin
        chk(ack, 1'h1);
        wrap_up;
      end
      @(posedge clk_i);
    end
  endtask
  task press(input [1:0] b, input [7:0] t);
    begin
      btn <= b;
      len <= t;
      go <= 1'h1;
      @(posedge clk_i);
      go <= 1'h0;
      @(posedge clk_i);
    end
  endtask
  task wait_msg(input [3:0] m, input integer lim);
    integer i;
    begin
      i = 0;
      while ((msg !== m || (lim == 0 && busy !== 1'h0)) && i < 2000) begin
        @(posedge clk_i);
        i = i + 1;
      end
      chk(msg, m);
      if (i == 2000) begin
        n_errors = n_errors + 1;
        wrap_up;
      end
    end
  endtask
  task vcase(input [15:0] v, input [1:0] f, input [3:0] m);
    begin
      vel <= v;
      repeat (5) @(posedge clk_i);
      chk({ovr, und}, f);
      wait_msg(m, 1);
    end
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, `AVC_REG_CAL_LO, 32'h0);
    chk(q, `AVC_CAL_LO_RST);
    wb(1'h0, `AVC_REG_CAL_HI, 32'h0);
    chk(q, `AVC_CAL_HI_RST);
    wb(1'h0, 8'h14, 32'h0);
    chk(q, 32'h0);
    chk(flow, 1'h0);
    // random settings; the first sixteen walk every range and unit pair
    for (k = 0; k < 24; k = k + 1) begin
      seed = xs(seed);
      s = seed[7:0];
      if (k < 16)
        s = {s[7:5], k[3:2], s[2], k[1:0]};
      x = (s[3] & s[4]) ? {4'h0, seed[19:8]} : {11'h000, seed[12:8]};
      sw <= s;
      vel <= x;
      repeat (5) @(posedge clk_i);
      chk(fs, fs_of(s));
      chk(imp, s[3] & s[4]);
      chk(v10, s[5]);
      chk(dir, s[6]);
      x = (x > fs_of(s)) ? fs_of(s) : x;
      chk(lvl, s[6] ? x : fs_of(s) - x);
      chk(msg, `AVC_MSG_HOME);
    end
    sw <= 8'hFF;
    wb(1'h1, `AVC_REG_CAL_LO, 32'h00000064);
    wb(1'h1, `AVC_REG_CAL_HI, 32'h000000C8);
    vcase(16'h00FA, 2'h2, `AVC_MSG_OVER);
    fault <= 1'h1;
    wait_msg(`AVC_MSG_DAMAGE, 1);
    fault <= 1'h0;
    vcase(16'h0032, 2'h1, `AVC_MSG_UNDER);
    press(2'h1, 8'h06);
    wait_msg(`AVC_MSG_FAULT, 1);
    vcase(16'h0096, 2'h0, `AVC_MSG_HOME);
    press(2'h2, 8'h06);
    wait_msg(`AVC_MSG_FAULT, 1);
    wait_msg(`AVC_MSG_HOME, 0);
    // zero hold: nothing may change until the release delay has run
    press(2'h1, 8'h06);
    wait_msg(`AVC_MSG_HOME, 0);
    repeat (20) @(posedge clk_i);
    chk(msg, `AVC_MSG_HOME);
    wait_msg(`AVC_MSG_ZERO, 1);
    wb(1'h0, `AVC_REG_ZERO, 32'h0);
    chk(q, 32'h00000096);
    chk(lvl, 16'h0000);
    vel <= 16'h00B4;
    wait_msg(`AVC_MSG_HOME, 1);
    press(2'h2, 8'h06);
    wait_msg(`AVC_MSG_SPAN, 1);
    wb(1'h0, `AVC_REG_SPAN, 32'h0);
    chk(q, 32'h000000B4);
    wait_msg(`AVC_MSG_HOME, 0);
    // window long gone, so this span hold must be ignored
    repeat (250) @(posedge clk_i);
    press(2'h2, 8'h06);
    k = 0;
    repeat (150) begin
      @(posedge clk_i);
      k = k + (msg === `AVC_MSG_SPAN);
    end
    chk(k, 0);
    press(2'h3, 8'h08);
    wait_msg(`AVC_MSG_SECU, 1);
    wait_msg(`AVC_MSG_LEVEL, 0);
    chk(sl, 2'h0);
    press(2'h2, 8'h06);
    wait_msg(`AVC_MSG_MENU, 1);
    // a zero tap in the menu toggles flow mode only with a display attached
    for (k = 0; k < 2; k = k + 1) begin
      wait_msg(`AVC_MSG_MENU, 0);
      disp <= k[0];
      press(2'h1, 8'h03);
      repeat (60) @(posedge clk_i);
      chk(flow, k[0]);
    end
    wrap_up;
  end
endmodule
